// file: include/host_chan_cfg.svh
// constants of the dual-channel host port: offsets, fields, reset values, timing
// assumes a single 25 MHz clock and a host bus sampled on that clock
// Function
// - power-down high stops the oscillator and isolates host pins at once
// - low-power state lasts while power-down is high, ends after it falls
// - falling power-down edge resets every register of both channels
// - strap high or floating selects separate read and write strobes
// - strap low selects one read/write line with one shared select
// - host selects a channel by a low select; high selects are ignored
// - strobe style: select A low hits A, select B low with select A high hits B
// - rw-line style: shared select low hits A or B by address bit
// - transmitter frames characters with start, optional parity, and stop bits
// - receiver checks parity of each character and flags mismatches
// - serial logic reaches 5 Mbit/s bit rate at its fastest
// - three address bits pick a register; general set needs divisor-latch bit zero
`ifndef HOST_CHAN_CFG_SVH
`define HOST_CHAN_CFG_SVH
// ---------------------------------------------------------------
// register offsets within a channel
// ---------------------------------------------------------------
`define REG_DATA  3'h0
`define REG_IER   3'h1
`define REG_LCR   3'h3
`define REG_MCR   3'h4
`define REG_LSR   3'h5
`define REG_SPR   3'h7
`define REG_DLL   3'h0
`define REG_DLM   3'h1
// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define LCR_DLAB  7
`define LCR_EPS   4
`define LCR_PEN   3
`define LCR_STB   2
`define LSR_DR    0
`define LSR_PE    2
`define LSR_THRE  5
`define LSR_TEMT  6
`define REG_RST   8'h00
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_MHZ      25
`define SER_MAX_MBPS 5
`define MIN_DIV      16'((`CLK_MHZ + `SER_MAX_MBPS - 1) / `SER_MAX_MBPS)
`endif

// file: include/host_chan_pkg.sv
// types shared by the host port and the character framer
// assumes the constants header is included by the design files
package host_chan_pkg;
	typedef enum logic [1:0] {
		BUS_STROBES = 2'b01,
		BUS_RWLINE  = 2'b10
	} bus_style_t;
	typedef enum logic [4:0] {
		PH_IDLE  = 5'b00001,
		PH_START = 5'b00010,
		PH_DATA  = 5'b00100,
		PH_PAR   = 5'b01000,
		PH_STOP  = 5'b10000
	} phase_t;
	typedef enum logic [8:0] {
		T_NONE = 9'h001,
		T_DATA = 9'h002,
		T_IER  = 9'h004,
		T_LCR  = 9'h008,
		T_MCR  = 9'h010,
		T_LSR  = 9'h020,
		T_SPR  = 9'h040,
		T_DLL  = 9'h080,
		T_DLM  = 9'h100
	} reg_t;
endpackage : host_chan_pkg

// file: design/char_framer.sv
// one channel's serial engine: frames outgoing bytes, checks incoming ones
// assumes rx_i already synchronous; eight data bits, bit time = divisor cycles, never under MIN_DIV
`timescale 1ns/1ps
`include "host_chan_cfg.svh"
module char_framer (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        clear_i,
	input  wire logic [7:0]  lcr_i,
	input  wire logic [15:0] divisor_i,
	input  wire logic        tx_load_i,
	input  wire logic [7:0]  tx_data_i,
	output logic             tx_busy_o,
	output logic             tx_o,
	input  wire logic        rx_i,
	output logic             rx_valid_o,
	output logic [7:0]       rx_data_o,
	output logic             rx_parity_err_o
);
	// parity bit value for a byte; even when eps is set
	function automatic logic par_bit(input logic [7:0] d, input logic eps);
		par_bit = (^d) ^ ~eps;
	endfunction : par_bit

	host_chan_pkg::phase_t tx_ph_q, rx_ph_q;
	logic [15:0] tx_cnt_q, rx_cnt_q;
	logic [2:0]  tx_bit_q, rx_bit_q;
	logic [7:0]  tx_sh_q, rx_sh_q;
	logic        tx_par_q, tx_stop2_q;
	wire  [15:0] bit_div = (divisor_i < `MIN_DIV) ? `MIN_DIV : divisor_i;
	wire         tx_tick = (tx_cnt_q == 16'h0000);
	wire         rx_tick = (rx_cnt_q == 16'h0000);
	wire         pen     = lcr_i[`LCR_PEN];
	assign tx_busy_o = (tx_ph_q != host_chan_pkg::PH_IDLE);

	// ---------------------------------------------------------------
	// transmitter: start bit, data lsb first, parity, one or two stops
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i || clear_i) begin
			tx_ph_q <= host_chan_pkg::PH_IDLE;
			tx_cnt_q <= 16'h0000;
			tx_bit_q <= 3'h0;
			tx_sh_q <= 8'h00;
			tx_par_q <= 1'b0;
			tx_stop2_q <= 1'b0;
			tx_o <= 1'b1;
		end else begin
			tx_cnt_q <= (tx_tick || !tx_busy_o) ? bit_div - 16'h0001 : tx_cnt_q - 16'h0001;
			unique case (tx_ph_q)
				host_chan_pkg::PH_IDLE: if (tx_load_i) begin
					tx_ph_q <= host_chan_pkg::PH_START;
					tx_o <= 1'b0;
					tx_sh_q <= tx_data_i;
					tx_par_q <= par_bit(tx_data_i, lcr_i[`LCR_EPS]);
					tx_stop2_q <= lcr_i[`LCR_STB];
				end
				host_chan_pkg::PH_START: if (tx_tick) begin
					tx_ph_q <= host_chan_pkg::PH_DATA;
					tx_o <= tx_sh_q[0];
					tx_bit_q <= 3'h0;
				end
				host_chan_pkg::PH_DATA: if (tx_tick) begin
					tx_bit_q <= tx_bit_q + 3'h1;
					tx_sh_q <= {1'b0, tx_sh_q[7:1]};
					if (tx_bit_q != 3'h7) begin
						tx_o <= tx_sh_q[1];
					end else if (pen) begin
						tx_ph_q <= host_chan_pkg::PH_PAR;
						tx_o <= tx_par_q;
					end else begin
						tx_ph_q <= host_chan_pkg::PH_STOP;
						tx_o <= 1'b1;
					end
				end
				host_chan_pkg::PH_PAR: if (tx_tick) begin
					tx_ph_q <= host_chan_pkg::PH_STOP;
					tx_o <= 1'b1;
				end
				host_chan_pkg::PH_STOP: if (tx_tick) begin
					if (tx_stop2_q) tx_stop2_q <= 1'b0;
					else tx_ph_q <= host_chan_pkg::PH_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// receiver: mid-bit sampling, parity compared before the stop bit
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i || clear_i) begin
			rx_ph_q <= host_chan_pkg::PH_IDLE;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rx_valid_o <= 1'b0;
			rx_data_o <= 8'h00;
			rx_parity_err_o <= 1'b0;
		end else begin
			rx_valid_o <= 1'b0;
			rx_cnt_q <= rx_tick ? bit_div - 16'h0001 : rx_cnt_q - 16'h0001;
			unique case (rx_ph_q)
				host_chan_pkg::PH_IDLE: if (!rx_i) begin
					rx_ph_q <= host_chan_pkg::PH_START;
					rx_cnt_q <= {1'b0, bit_div[15:1]}; // lands mid start bit
				end
				host_chan_pkg::PH_START: if (rx_tick) begin
					rx_ph_q <= rx_i ? host_chan_pkg::PH_IDLE : host_chan_pkg::PH_DATA;
					rx_bit_q <= 3'h0;
				end
				host_chan_pkg::PH_DATA: if (rx_tick) begin
					rx_sh_q <= {rx_i, rx_sh_q[7:1]};
					rx_bit_q <= rx_bit_q + 3'h1;
					if (rx_bit_q == 3'h7)
						rx_ph_q <= pen ? host_chan_pkg::PH_PAR : host_chan_pkg::PH_STOP;
				end
				host_chan_pkg::PH_PAR: if (rx_tick) begin
					rx_ph_q <= host_chan_pkg::PH_STOP;
					rx_parity_err_o <= (rx_i != par_bit(rx_sh_q, lcr_i[`LCR_EPS]));
				end
				host_chan_pkg::PH_STOP: if (rx_tick) begin
					rx_ph_q <= host_chan_pkg::PH_IDLE;
					rx_valid_o <= 1'b1;
					rx_data_o <= rx_sh_q;
				end
			endcase
			if (rx_valid_o) rx_parity_err_o <= 1'b0; // flag pulses with the byte
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || clear_i);
	start_bit_a: assert property (tx_load_i && !tx_busy_o |=> !tx_o [*2])
		else $error("start bit not driven after load");
	parity_err_a: assert property (
		rx_ph_q == host_chan_pkg::PH_PAR && rx_tick
		&& rx_i != par_bit(rx_sh_q, lcr_i[`LCR_EPS]) |=> rx_parity_err_o)
		else $error("parity mismatch not flagged");
	bit_floor_a: assert property (tx_busy_o |-> tx_cnt_q < bit_div)
		else $error("bit counter beyond bit time");
	rx_char_c: cover property (rx_valid_o && rx_parity_err_o);
endmodule : char_framer

// file: design/host_chan_select_power.sv
// host front end of a two-channel serial port: bus style, channel select,
// register decode, and the power-down input with its wake reset
// assumes all host pins synchronous to clk_i; strap may change only at rest
`timescale 1ns/1ps
`include "host_chan_cfg.svh"
module host_chan_select_power (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       power_down_request_i,
	input  wire logic       bus_style_i,
	input  wire logic       chan_a_select_n_i,
	input  wire logic       chan_b_select_n_i,
	input  wire logic       channel_address_bit_i,
	input  wire logic [2:0] addr_i,
	input  wire logic       read_n_i,
	input  wire logic       write_n_i,
	input  wire logic       rw_i,
	input  wire logic [7:0] data_i,
	output logic [7:0]      data_o,
	output logic            data_oe_o,
	output logic            osc_enable_o,
	output logic            host_isolate_o,
	output logic            chan_a_hit_o,
	output logic            chan_b_hit_o,
	output logic [1:0]      tx_o,
	input  wire logic [1:0] rx_i
);
	// offset to register target; divisor latch bit swaps the low offsets
	function automatic host_chan_pkg::reg_t reg_target(input logic [2:0] idx,
		input logic dlab);
		reg_target = host_chan_pkg::T_NONE;
		if (idx == `REG_LCR) reg_target = host_chan_pkg::T_LCR;
		else if (dlab) begin
			if (idx == `REG_DLL) reg_target = host_chan_pkg::T_DLL;
			else if (idx == `REG_DLM) reg_target = host_chan_pkg::T_DLM;
		end else begin
			case (idx)
				`REG_DATA: reg_target = host_chan_pkg::T_DATA;
				`REG_IER:  reg_target = host_chan_pkg::T_IER;
				`REG_MCR:  reg_target = host_chan_pkg::T_MCR;
				`REG_LSR:  reg_target = host_chan_pkg::T_LSR;
				`REG_SPR:  reg_target = host_chan_pkg::T_SPR;
				default:   reg_target = host_chan_pkg::T_NONE;
			endcase
		end
	endfunction : reg_target

	// ---------------------------------------------------------------
	// power-down and wake reset
	// ---------------------------------------------------------------
	logic pd_prev_q, wake_rst_q;
	// oscillator gate and pin isolation follow the input with no delay
	assign osc_enable_o   = !power_down_request_i;
	assign host_isolate_o = power_down_request_i;
	// falling edge of power-down gives a one-cycle register reset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pd_prev_q <= 1'b0;
			wake_rst_q <= 1'b0;
		end else begin
			pd_prev_q <= power_down_request_i;
			wake_rst_q <= pd_prev_q && !power_down_request_i;
		end
	end
	// the edge that first sees the input low is held off too, or a write there would be lost
	wire bus_blocked = power_down_request_i || pd_prev_q || wake_rst_q;

	// ---------------------------------------------------------------
	// bus style and channel decode
	// ---------------------------------------------------------------
	host_chan_pkg::bus_style_t bus_mode;
	// strap high (or pulled up) means strobes, low means rw line
	assign bus_mode = bus_style_i ? host_chan_pkg::BUS_STROBES
		: host_chan_pkg::BUS_RWLINE;
	wire strobes = (bus_mode == host_chan_pkg::BUS_STROBES);
	// both selects low in strobe style is the host's fault; A is given priority
	wire sel_a = strobes ? !chan_a_select_n_i
		: (!chan_a_select_n_i && !channel_address_bit_i);
	wire sel_b = strobes ? (chan_a_select_n_i && !chan_b_select_n_i)
		: (!chan_a_select_n_i && channel_address_bit_i);
	wire rd_act = strobes ? !read_n_i : rw_i;
	wire wr_act = strobes ? !write_n_i : !rw_i;
	// selects high mean no cycle at all, whatever the strobes do
	wire hit = (sel_a || sel_b) && (rd_act || wr_act) && !bus_blocked;
	assign chan_a_hit_o = hit && sel_a;
	assign chan_b_hit_o = hit && sel_b;
	logic hit_q;
	wire  acc_new = hit && !hit_q; // side effects once per cycle of the host
	wire  chan = sel_b;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) hit_q <= 1'b0;
		else hit_q <= hit;
	end

	// ---------------------------------------------------------------
	// per-channel registers and serial engine
	// ---------------------------------------------------------------
	logic [7:0] lcr_q [2];
	logic [7:0] ier_q [2];
	logic [7:0] mcr_q [2];
	logic [7:0] spr_q [2];
	logic [7:0] dll_q [2];
	logic [7:0] dlm_q [2];
	logic [7:0] rbr_q [2];
	logic [7:0] rx_byte [2];
	logic [7:0] rd_word [2];
	logic       dr_q [2];
	logic       pe_q [2];
	logic       tx_busy [2];
	logic       rx_valid [2];
	logic       rx_par [2];
	host_chan_pkg::reg_t cur_tgt;
	assign cur_tgt = reg_target(addr_i, lcr_q[chan][`LCR_DLAB]);

	generate
		for (genvar g = 0; g < 2; g++) begin : g_chan
			wire mine  = acc_new && (chan == 1'(g));
			wire we    = mine && wr_act;
			wire rd_go = mine && rd_act;
			wire [7:0] lsr = {1'b0, !tx_busy[g], !tx_busy[g], 2'b00, pe_q[g], 1'b0, dr_q[g]};
			// register writes; wake reset returns all to defaults
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i || wake_rst_q) begin
					lcr_q[g] <= `REG_RST;
					ier_q[g] <= `REG_RST;
					mcr_q[g] <= `REG_RST;
					spr_q[g] <= `REG_RST;
					dll_q[g] <= `REG_RST;
					dlm_q[g] <= `REG_RST;
				end else if (we) begin
					if (cur_tgt == host_chan_pkg::T_LCR) lcr_q[g] <= data_i;
					if (cur_tgt == host_chan_pkg::T_IER) ier_q[g] <= data_i;
					if (cur_tgt == host_chan_pkg::T_MCR) mcr_q[g] <= data_i;
					if (cur_tgt == host_chan_pkg::T_SPR) spr_q[g] <= data_i;
					if (cur_tgt == host_chan_pkg::T_DLL) dll_q[g] <= data_i;
					if (cur_tgt == host_chan_pkg::T_DLM) dlm_q[g] <= data_i;
				end
			end
			// receive flags: a new byte or error beats the read that clears it
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i || wake_rst_q) begin
					rbr_q[g] <= `REG_RST;
					dr_q[g] <= 1'b0;
					pe_q[g] <= 1'b0;
				end else begin
					dr_q[g] <= rx_valid[g] || (dr_q[g] && !(rd_go
						&& cur_tgt == host_chan_pkg::T_DATA));
					pe_q[g] <= rx_par[g] || (pe_q[g] && !(rd_go
						&& cur_tgt == host_chan_pkg::T_LSR));
					if (rx_valid[g]) rbr_q[g] <= rx_byte[g];
				end
			end
			// read selection by target
			assign rd_word[g] = (cur_tgt == host_chan_pkg::T_DATA) ? rbr_q[g]
				: (cur_tgt == host_chan_pkg::T_IER) ? ier_q[g]
				: (cur_tgt == host_chan_pkg::T_LCR) ? lcr_q[g]
				: (cur_tgt == host_chan_pkg::T_MCR) ? mcr_q[g]
				: (cur_tgt == host_chan_pkg::T_LSR) ? lsr
				: (cur_tgt == host_chan_pkg::T_SPR) ? spr_q[g]
				: (cur_tgt == host_chan_pkg::T_DLL) ? dll_q[g]
				: (cur_tgt == host_chan_pkg::T_DLM) ? dlm_q[g] : 8'h00;
			// a write to a busy transmitter is dropped: there is no holding fifo
			char_framer u_framer (
				.clk_i           (clk_i),
				.rst_i           (rst_i),
				.clear_i         (wake_rst_q),
				.lcr_i           (lcr_q[g]),
				.divisor_i       ({dlm_q[g], dll_q[g]}),
				.tx_load_i       (we && cur_tgt == host_chan_pkg::T_DATA),
				.tx_data_i       (data_i),
				.tx_busy_o       (tx_busy[g]),
				.tx_o            (tx_o[g]),
				.rx_i            (rx_i[g]),
				.rx_valid_o      (rx_valid[g]),
				.rx_data_o       (rx_byte[g]),
				.rx_parity_err_o (rx_par[g])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// read data path
	// ---------------------------------------------------------------
	logic [7:0] data_q;
	// data registered, so it is valid from the second cycle of a read
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) data_q <= 8'h00;
		else if (hit && rd_act) data_q <= rd_word[chan];
	end
	assign data_o    = data_q;
	assign data_oe_o = hit && rd_act;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	pins_isolate_a: assert property (power_down_request_i |->
		!osc_enable_o && host_isolate_o && !data_oe_o)
		else $error("host pins not isolated in power-down");
	stay_down_a: assert property (power_down_request_i [*2] |->
		!chan_a_hit_o && !chan_b_hit_o && !$rose(osc_enable_o))
		else $error("left low power while input held");
	wake_reset_a: assert property ($fell(power_down_request_i) |=> wake_rst_q
		##1 (lcr_q[0] == `REG_RST && lcr_q[1] == `REG_RST && dll_q[1] == `REG_RST))
		else $error("registers not reset after wake");
	strobe_style_a: assert property (bus_style_i && !chan_a_select_n_i
		&& !read_n_i && !bus_blocked |-> chan_a_hit_o && data_oe_o)
		else $error("strobe style read not taken");
	rwline_idle_a: assert property (!bus_style_i && chan_a_select_n_i |->
		!chan_a_hit_o && !chan_b_hit_o)
		else $error("rw-line access with select high");
	idle_select_a: assert property (chan_a_select_n_i && chan_b_select_n_i |->
		!data_oe_o && !chan_a_hit_o && !chan_b_hit_o)
		else $error("access taken with selects high");
	strobe_chan_b_a: assert property (bus_style_i && chan_a_select_n_i
		&& !chan_b_select_n_i && !write_n_i && !bus_blocked |-> chan_b_hit_o && !chan_a_hit_o)
		else $error("channel b not selected");
	addr_bit_a: assert property (!bus_style_i && !chan_a_select_n_i
		&& !bus_blocked |-> (chan_b_hit_o == channel_address_bit_i) && (chan_a_hit_o
		!= channel_address_bit_i))
		else $error("address bit routed wrong");
	dlab_gate_a: assert property (acc_new && addr_i == `REG_DATA |->
		cur_tgt == (lcr_q[chan][`LCR_DLAB] ? host_chan_pkg::T_DLL : host_chan_pkg::T_DATA))
		else $error("offset zero decoded against the divisor bit");
	wake_block_a: assert property (wake_rst_q |-> !chan_a_hit_o && !chan_b_hit_o)
		else $error("access during wake reset");
	wake_c: cover property ($fell(power_down_request_i) ##2 chan_a_hit_o);
	rwline_b_c: cover property (!bus_style_i && chan_b_hit_o && rw_i);
	tx_start_c: cover property (acc_new && wr_act && cur_tgt == host_chan_pkg::T_DATA);
endmodule : host_chan_select_power

// file: verif/host_cpu_model.sv
// host processor model: drives the parallel bus pins and the serial inputs
// assumes one caller at a time, all changes right after a rising clk_i edge
`timescale 1ns/1ps
module host_cpu_model #(
	parameter int BIT_CLKS = 5
) (
	input  wire logic       clk_i,
	input  wire logic [7:0] rd_data_i,
	input  wire logic [1:0] tx_i,
	output logic [6:0]      pins_o,
	output logic [2:0]      addr_o,
	output logic [7:0]      wr_data_o,
	output logic [1:0]      rx_o
);
	// pins_o = {style, sel_a_n, sel_b_n, chan bit, read_n, write_n, rw}
	logic       loop_q = 1'b1;
	logic [1:0] rx_q   = 2'h3;
	initial begin
		pins_o    = 7'h77;
		addr_o    = 3'h0;
		wr_data_o = 8'h00;
	end
	// serial lines looped back unless a frame is forced; forced lines idle high
	assign rx_o = loop_q ? tx_i : rx_q;
	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	task automatic drive(input logic [6:0] p, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		pins_o    <= p;
		addr_o    <= a;
		wr_data_o <= d;
	endtask : drive
	// one select only, so the read bus is never contended; release leaves an idle cycle
	task automatic access(input logic st, input logic ch, input logic wr,
		input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
		drive({st, st & ch, ~st | ~ch, ch, ~(st & ~wr), ~(st & wr), ~wr}, a, d);
		@(posedge clk_i);
		@(posedge clk_i);
		q = rd_data_i;
		pins_o <= {st, 6'h37};
	endtask : access
	// ----------------------------------------------------------------
	// serial frame with parity optionally spoiled
	// ----------------------------------------------------------------
	task automatic send_frame(input int ch, input logic [7:0] d, input logic bad);
		logic [10:0] f;
		f = {1'b1, (^d) ^ bad, d, 1'b0};
		@(posedge clk_i);
		loop_q <= 1'b0;
		for (int i = 0; i < 11; i++) begin
			rx_q[ch] <= f[i];
			repeat (BIT_CLKS) @(posedge clk_i);
		end
		loop_q <= 1'b1;
	endtask : send_frame
endmodule : host_cpu_model

// file: verif/host_chan_select_power_test.sv
// self-checking bench for the host port: decode table, registers, serial, power-down
// assumes the design's serial outputs may loop back to its inputs through the model
`timescale 1ns/1ps
`define CHECK_EQ(what, e, g) \
	begin \
		n_tests++; \
		if ((g) !== (e)) begin \
			n_mismatch++; \
			$display("ERROR %s expected %h seen %h", what, e, g); \
		end \
	end
module host_chan_select_power_test;
	typedef struct packed {
		logic [6:0] pins;
		logic [2:0] hits;
	} row_t;
	// {style, sel_a_n, sel_b_n, chan bit, read_n, write_n, rw} -> {hit a, hit b, oe}
	localparam row_t ROWS [10] = '{{7'h53, 3'h5}, {7'h63, 3'h3}, {7'h55, 3'h4},
		{7'h65, 3'h2}, {7'h73, 3'h0}, {7'h57, 3'h0}, {7'h17, 3'h5}, {7'h1e, 3'h2},
		{7'h0f, 3'h3}, {7'h2f, 3'h0}};
	logic        clk_i                = 1'b0;
	logic        rst_i                = 1'b1;
	logic        power_down_request_i = 1'b0;
	logic [6:0]  pins;
	logic [2:0]  addr;
	logic [7:0]  wr_data;
	logic [7:0]  data_o;
	logic [7:0]  q;
	logic [10:0] frame;
	logic        data_oe_o;
	logic        osc_enable_o;
	logic        host_isolate_o;
	logic        chan_a_hit_o;
	logic        chan_b_hit_o;
	logic [1:0]  tx_o;
	logic [1:0]  rx;
	wire  [2:0]  seen_hits = {chan_a_hit_o, chan_b_hit_o, data_oe_o}; // same order as a row
	int          n_mismatch = 0;
	int          n_tests    = 0;
	int          cycles     = 0;
	host_chan_select_power uut (
		.clk_i(clk_i), .rst_i(rst_i), .power_down_request_i(power_down_request_i),
		.bus_style_i(pins[6]), .chan_a_select_n_i(pins[5]), .chan_b_select_n_i(pins[4]),
		.channel_address_bit_i(pins[3]), .addr_i(addr), .read_n_i(pins[2]),
		.write_n_i(pins[1]), .rw_i(pins[0]), .data_i(wr_data), .data_o(data_o),
		.data_oe_o(data_oe_o), .osc_enable_o(osc_enable_o), .host_isolate_o(host_isolate_o),
		.chan_a_hit_o(chan_a_hit_o), .chan_b_hit_o(chan_b_hit_o), .tx_o(tx_o), .rx_i(rx));
	host_cpu_model cpu (
		.clk_i(clk_i), .rd_data_i(data_o), .tx_i(tx_o), .pins_o(pins), .addr_o(addr),
		.wr_data_o(wr_data), .rx_o(rx));
	// ----------------------------------------------------------------
	// clock, cycle limit, closing report
	// ----------------------------------------------------------------
	initial forever #20 clk_i = ~clk_i;
	// the whole run needs some 320 cycles; a hang stops well short of forever
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			n_mismatch++;
			$display("ERROR cycle limit expected %0d seen %0d", 1999, cycles);
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	task automatic rd(input logic st, input logic ch, input logic [2:0] a, input logic [7:0] e);
		cpu.access(st, ch, 1'b0, a, 8'h00, q);
		`CHECK_EQ("read data", e, q)
	endtask : rd
	task automatic wr(input logic st, input logic ch, input logic [2:0] a, input logic [7:0] d);
		cpu.access(st, ch, 1'b1, a, d, q);
	endtask : wr
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		`CHECK_EQ("reset outputs", 12'hc02, {tx_o, data_o, osc_enable_o, host_isolate_o})
		rst_i <= 1'b0;
		$display("test reset done");
		// release between rows already carries the next row's strap, so it moves at rest
		foreach (ROWS[i]) begin
			cpu.drive(ROWS[i].pins, 3'h7, 8'h00);
			@(negedge clk_i);
			`CHECK_EQ("hits", ROWS[i].hits, seen_hits)
			cpu.drive({ROWS[(i + 1) % 10].pins[6], 6'h37}, 3'h7, 8'h00);
		end
		$display("test decode done");
		wr(1'b1, 1'b0, 3'h7, 8'h5a);
		wr(1'b1, 1'b1, 3'h7, 8'ha5);
		cpu.drive(7'h37, 3'h0, 8'h00);
		rd(1'b0, 1'b0, 3'h7, 8'h5a);
		rd(1'b0, 1'b1, 3'h7, 8'ha5);
		rd(1'b0, 1'b0, 3'h2, 8'h00);
		wr(1'b0, 1'b0, 3'h3, 8'h80);
		wr(1'b0, 1'b0, 3'h0, 8'h01);
		rd(1'b0, 1'b0, 3'h0, 8'h01);
		rd(1'b0, 1'b0, 3'h7, 8'h00);
		wr(1'b0, 1'b0, 3'h3, 8'h18);
		rd(1'b0, 1'b0, 3'h7, 8'h5a);
		$display("test registers done");
		// odd then even parity; divisor 1 is below the floor, so bits last five clocks
		for (int m = 0; m < 2; m++) begin
			wr(1'b0, 1'b0, 3'h3, m ? 8'h18 : 8'h08);
			wr(1'b0, 1'b0, 3'h0, 8'hc1);
			repeat (2) @(negedge clk_i);
			for (int i = 0; i < 11; i++) begin
				frame[i] = tx_o[0];
				repeat (5) @(negedge clk_i);
			end
			`CHECK_EQ("tx frame", {1'b1, ~^8'hc1 ^ m[0], 8'hc1, 1'b0}, frame)
			rd(1'b0, 1'b0, 3'h5, 8'h61);
			rd(1'b0, 1'b0, 3'h0, 8'hc1);
			rd(1'b0, 1'b0, 3'h5, 8'h60);
		end
		cpu.send_frame(0, 8'h3c, 1'b1);
		repeat (5) @(posedge clk_i);
		rd(1'b0, 1'b0, 3'h5, 8'h65);
		rd(1'b0, 1'b0, 3'h5, 8'h61);
		rd(1'b0, 1'b0, 3'h0, 8'h3c);
		$display("test serial done");
		wr(1'b0, 1'b1, 3'h7, 8'h77);
		@(posedge clk_i);
		power_down_request_i <= 1'b1;
		@(negedge clk_i);
		`CHECK_EQ("power pins", 2'h1, {osc_enable_o, host_isolate_o})
		cpu.drive(7'h1e, 3'h7, 8'h11);
		repeat (10) @(negedge clk_i);
		`CHECK_EQ("asleep", 4'h1, {seen_hits, host_isolate_o})
		// the write stays on the pins while the input falls: it must not be taken
		@(posedge clk_i);
		power_down_request_i <= 1'b0;
		@(negedge clk_i);
		`CHECK_EQ("wake pins", 2'h2, {osc_enable_o, host_isolate_o})
		`CHECK_EQ("wake hold-off", 3'h0, seen_hits)
		cpu.drive(7'h37, 3'h0, 8'h00);
		repeat (3) @(posedge clk_i);
		rd(1'b0, 1'b1, 3'h7, 8'h00);
		rd(1'b0, 1'b0, 3'h7, 8'h00);
		rd(1'b0, 1'b0, 3'h3, 8'h00);
		$display("test power-down done");
		end_sim();
	end
endmodule : host_chan_select_power_test
